// File: core/ext_irq_pkg.sv
// Constants for the external request and transfer timing block
// Summary of operation
// - Flag set at fetch of N: arbitrate next cycle, inject transfer, clear flag.
// - Reading transfer channel controls during arbitration repeats it, one cycle later.
// - Minimum start is 3 clocks after last-clock flag set, 4 after first-clock.
// - Each hold condition N-2/N-1 or N-1/N adds one clock.
// - Flash operand read or branch-type instruction N adds two clocks.
// - N reading status word after N-1 alters flags adds two clocks.
// - Internal latency capped at 9 clocks; only external bus conflicts and a repeated arbitration extend it.
// - Fully external case costs seven word bus accesses of waiting.
// - After acknowledge, next instruction stalls two clocks plus operand transfer time.
// - Every request pin selects rising, falling or both edges in its control.
// - Capcom mode 001 rising, 010 falling, 011 both edges set its flag.
// - Each selected capcom edge latches the capcom timer into the capture register, except on channels 8-15 while their fast edge code is not 00.
// - Enabled capcom flag yields a transfer request or a vectored interrupt.
// - Auxiliary timer pins request only with mode field 101.
// - Auxiliary edge field x01 rising, x10 falling, x11 both edges.
// - Auxiliary edge captures core timer three; enable raises a request.
// - Capture enable clear: capture pin sets flag only, reload register untouched.
// - Capture edge field 01 rising, 10 falling, 11 both; enable raises request.
// - Standard pins sampled once every 8 clocks.
// - Eight fast inputs sampled every clock, edges chosen in fast edge control.
// - Fast inputs may take an alternate peripheral source via source select.
// - With power-down config bit set, fast inputs can end power-down.
// - Fast edge code 00 off, 01 rising, 10 falling, 11 any edge.
// - Fast source code 00 pin, 01 alternate, 10 OR, 11 AND.
package ext_irq_pkg;
    localparam int NUM_CC = 16;
    localparam int NUM_FAST = 8;
    localparam int FAST_BASE = 8;
    localparam int NUM_SRC = 19;
    localparam int SRC_AUX_A = 16;
    localparam int SRC_AUX_B = 17;
    localparam int SRC_CAP = 18;
    localparam int SRC_W = 5;
    localparam int TIMER_W = 16;
    localparam int ADDR_W = 8;
    // Byte addresses
    localparam logic [7:0] OFS_CC_MODE_LO = 8'h00;
    localparam logic [7:0] OFS_CC_MODE_HI = 8'h04;
    localparam logic [7:0] OFS_IRQ_EN = 8'h08;
    localparam logic [7:0] OFS_XFER_SEL = 8'h0c;
    localparam logic [7:0] OFS_FLAGS = 8'h10;
    localparam logic [7:0] OFS_AUX_A_CTRL = 8'h14;
    localparam logic [7:0] OFS_AUX_B_CTRL = 8'h18;
    localparam logic [7:0] OFS_CAP_CTRL = 8'h1c;
    localparam logic [7:0] OFS_FAST_EDGE = 8'h20;
    localparam logic [7:0] OFS_FAST_SRC = 8'h24;
    localparam logic [7:0] OFS_SYS_CFG = 8'h28;
    localparam logic [7:0] OFS_AUX_A_VAL = 8'h2c;
    localparam logic [7:0] OFS_AUX_B_VAL = 8'h30;
    localparam logic [7:0] OFS_CAPTURE_RELOAD_REGISTER = 8'h34;
    localparam logic [7:0] OFS_STATUS = 8'h38;
    localparam logic [7:0] OFS_CC_CAP_BASE = 8'h40;
    // Field codes
    localparam logic [2:0] AUX_MODE_CAPTURE = 3'h5;
    localparam int CAP_EN_BIT = 2;
    localparam int PWD_CFG_BIT = 0;
    // Timing in CPU clocks
    localparam logic [3:0] LAT_LAST_CLK = 4'h3;
    localparam logic [3:0] LAT_FIRST_CLK = 4'h4;
    localparam logic [3:0] LAT_HOLD = 4'h1;
    localparam logic [3:0] LAT_SLOW_OP = 4'h2;
    localparam logic [3:0] LAT_PSW = 4'h2;
    localparam logic [3:0] LAT_MAX = 4'h9;
    localparam logic [1:0] RESUME_CLKS = 2'h2;
    localparam logic [2:0] SAMPLE_LAST = 3'h7;
    typedef enum logic [1:0] {
        XS_IDLE = 2'b00,
        XS_ARB = 2'b01,
        XS_WAIT = 2'b10,
        XS_RESUME = 2'b11
    } xfer_state_t;
endpackage : ext_irq_pkg

// File: core/ext_irq_and_pec_timing.sv
// External edge request flags and transfer injection timing
`timescale 1ns/1ps
module ext_irq_and_pec_timing (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [ext_irq_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Asynchronous pins
    input wire logic [ext_irq_pkg::NUM_CC-1:0] cc_pin_in,
    input wire logic aux_timer_a_input,
    input wire logic aux_timer_b_input,
    input wire logic gpt_capture_pin,
    input wire logic [ext_irq_pkg::NUM_FAST-1:0] fast_alt_source,
    // Timers on the same clock
    input wire logic [ext_irq_pkg::TIMER_W-1:0] capcom_timer,
    input wire logic [ext_irq_pkg::TIMER_W-1:0] core_timer_three,
    // Pipeline conditions
    input wire logic flag_in_first_clk,
    input wire logic hold_n2_n1,
    input wire logic hold_n1_n,
    input wire logic n_slow_op,
    input wire logic n_psw_after_flags,
    input wire logic n_reads_channel_ctrl,
    input wire logic ext_bus_busy,
    input wire logic xfer_operand_busy,
    input wire logic powerdown_active,
    // Requests out
    output logic transfer_start,
    output logic [ext_irq_pkg::SRC_W-1:0] transfer_source,
    output logic instr_stall,
    output logic irq_req,
    output logic [ext_irq_pkg::SRC_W-1:0] irq_source,
    output logic wake_request
);
    import ext_irq_pkg::*;

    function automatic logic edge_hit(input logic [1:0] sel, input logic prev,
                                      input logic cur);
        edge_hit = (sel[0] & ~prev & cur) | (sel[1] & prev & ~cur);
    endfunction : edge_hit

    function automatic logic [TIMER_W-1:0] merge_be(input logic [TIMER_W-1:0] old,
                                                    input logic [31:0] wd,
                                                    input logic [3:0] be);
        logic [TIMER_W-1:0] res;
        res = old;
        for (int b = 0; b < TIMER_W / 8; b++) begin
            if (be[b]) begin
                res[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        merge_be = res;
    endfunction : merge_be

    // Registers
    logic [2:0] cc_mode_r [NUM_CC];
    logic [NUM_SRC-1:0] irq_en_r;
    logic [NUM_SRC-1:0] xfer_sel_r;
    logic [NUM_SRC-1:0] flag_r;
    logic [5:0] aux_a_ctrl_r;
    logic [5:0] aux_b_ctrl_r;
    logic [2:0] cap_ctrl_r;
    logic [15:0] fast_edge_r;
    logic [15:0] fast_src_r;
    logic sys_cfg_r;
    logic [TIMER_W-1:0] aux_a_val_r;
    logic [TIMER_W-1:0] aux_b_val_r;
    logic [TIMER_W-1:0] capture_reload_register_r;
    logic [TIMER_W-1:0] cc_cap_r [NUM_CC];

    // Bus access
    logic rd_seen;
    logic wr_now;
    // Read data fetched when the request is seen, so it stands at completion
    assign rd_seen = avs_read & avs_waitrequest;
    assign wr_now = avs_write & ~avs_waitrequest;

    always_ff @(posedge clk) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
        end
    end

    // Synchronisers
    localparam int NPIN = NUM_CC + 3 + NUM_FAST;
    logic [NPIN-1:0] sync1_r;
    logic [NPIN-1:0] sync2_r;
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= {fast_alt_source, gpt_capture_pin, aux_timer_b_input,
                        aux_timer_a_input, cc_pin_in};
            sync2_r <= sync1_r;
        end
    end

    // Standard sampling every 8 clocks
    logic [2:0] presc_r;
    logic [NUM_CC+2:0] std_cur_r;
    logic [NUM_CC+2:0] std_prev_r;
    logic std_tick_r;
    always_ff @(posedge clk) begin
        if (rst) begin
            presc_r <= '0;
            std_cur_r <= '0;
            std_prev_r <= '0;
            std_tick_r <= 1'b0;
        end else begin
            presc_r <= presc_r + 3'h1;
            std_tick_r <= (presc_r == SAMPLE_LAST);
            if (presc_r == SAMPLE_LAST) begin
                std_cur_r <= sync2_r[NUM_CC+2:0];
                std_prev_r <= std_cur_r;
            end
        end
    end

    // Fast inputs every clock with source selection
    logic [NUM_FAST-1:0] fast_cur;
    logic [NUM_FAST-1:0] fast_prev_r;
    logic [NUM_FAST-1:0] fast_on;
    always_comb begin
        for (int i = 0; i < NUM_FAST; i++) begin
            logic p;
            logic a;
            p = sync2_r[FAST_BASE+i];
            a = sync2_r[NUM_CC+3+i];
            fast_on[i] = fast_edge_r[2*i +: 2] != 2'b00;
            unique case (fast_src_r[2*i +: 2])
                2'b00: fast_cur[i] = p;
                2'b01: fast_cur[i] = a;
                2'b10: fast_cur[i] = p | a;
                2'b11: fast_cur[i] = p & a;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            fast_prev_r <= '0;
        end else begin
            fast_prev_r <= fast_cur;
        end
    end

    // Edge events per source
    logic [NUM_SRC-1:0] evt;
    logic [NUM_CC-1:0] cc_cap_evt;
    always_comb begin
        for (int i = 0; i < NUM_CC; i++) begin
            logic [1:0] sel;
            sel = (cc_mode_r[i][2] == 1'b0) ? cc_mode_r[i][1:0] : 2'b00;
            cc_cap_evt[i] = std_tick_r & edge_hit(sel, std_prev_r[i], std_cur_r[i]);
            if (i >= FAST_BASE && fast_on[i-FAST_BASE]) begin
                evt[i] = edge_hit(fast_edge_r[2*(i-FAST_BASE) +: 2],
                                  fast_prev_r[i-FAST_BASE], fast_cur[i-FAST_BASE]);
                cc_cap_evt[i] = 1'b0;
            end else begin
                evt[i] = cc_cap_evt[i];
            end
        end
        evt[SRC_AUX_A] = std_tick_r & (aux_a_ctrl_r[2:0] == AUX_MODE_CAPTURE) &
                         edge_hit(aux_a_ctrl_r[4:3], std_prev_r[SRC_AUX_A],
                                  std_cur_r[SRC_AUX_A]);
        evt[SRC_AUX_B] = std_tick_r & (aux_b_ctrl_r[2:0] == AUX_MODE_CAPTURE) &
                         edge_hit(aux_b_ctrl_r[4:3], std_prev_r[SRC_AUX_B],
                                  std_cur_r[SRC_AUX_B]);
        evt[SRC_CAP] = std_tick_r & edge_hit(cap_ctrl_r[1:0], std_prev_r[SRC_CAP],
                                             std_cur_r[SRC_CAP]);
    end

    // Capture registers
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < NUM_CC; i++) begin
                cc_cap_r[i] <= '0;
            end
            aux_a_val_r <= '0;
            aux_b_val_r <= '0;
            capture_reload_register_r <= '0;
        end else begin
            for (int i = 0; i < NUM_CC; i++) begin
                if (cc_cap_evt[i]) begin
                    cc_cap_r[i] <= capcom_timer;
                end
            end
            if (evt[SRC_AUX_A]) begin
                aux_a_val_r <= core_timer_three;
            end else if (wr_now && avs_address == OFS_AUX_A_VAL) begin
                aux_a_val_r <= merge_be(aux_a_val_r, avs_writedata, avs_byteenable);
            end
            if (evt[SRC_AUX_B]) begin
                aux_b_val_r <= core_timer_three;
            end else if (wr_now && avs_address == OFS_AUX_B_VAL) begin
                aux_b_val_r <= merge_be(aux_b_val_r, avs_writedata, avs_byteenable);
            end
            if (evt[SRC_CAP] && cap_ctrl_r[CAP_EN_BIT]) begin
                capture_reload_register_r <= core_timer_three;
            end else if (wr_now && avs_address == OFS_CAPTURE_RELOAD_REGISTER) begin
                capture_reload_register_r <= merge_be(capture_reload_register_r, avs_writedata, avs_byteenable);
            end
        end
    end

    // Control registers
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < NUM_CC; i++) begin
                cc_mode_r[i] <= '0;
            end
            irq_en_r <= '0;
            xfer_sel_r <= '0;
            aux_a_ctrl_r <= '0;
            aux_b_ctrl_r <= '0;
            cap_ctrl_r <= '0;
            fast_edge_r <= '0;
            fast_src_r <= '0;
            sys_cfg_r <= 1'b0;
        end else if (wr_now) begin
            unique case (avs_address)
                OFS_CC_MODE_LO: begin
                    for (int i = 0; i < 8; i++) begin
                        cc_mode_r[i] <= avs_writedata[3*i +: 3];
                    end
                end
                OFS_CC_MODE_HI: begin
                    for (int i = 0; i < 8; i++) begin
                        cc_mode_r[8+i] <= avs_writedata[3*i +: 3];
                    end
                end
                OFS_IRQ_EN: irq_en_r <= avs_writedata[NUM_SRC-1:0];
                OFS_XFER_SEL: xfer_sel_r <= avs_writedata[NUM_SRC-1:0];
                OFS_AUX_A_CTRL: aux_a_ctrl_r <= avs_writedata[5:0];
                OFS_AUX_B_CTRL: aux_b_ctrl_r <= avs_writedata[5:0];
                OFS_CAP_CTRL: cap_ctrl_r <= avs_writedata[2:0];
                OFS_FAST_EDGE: fast_edge_r <= avs_writedata[15:0];
                OFS_FAST_SRC: fast_src_r <= avs_writedata[15:0];
                OFS_SYS_CFG: sys_cfg_r <= avs_writedata[PWD_CFG_BIT];
                default: ;
            endcase
        end
    end

    // Transfer timing
    xfer_state_t state_r;
    logic [3:0] cnt_r;
    logic [1:0] resume_r;
    logic [SRC_W-1:0] src_r;
    logic [NUM_SRC-1:0] xfer_pend;
    logic [NUM_SRC-1:0] irq_pend;
    logic xfer_any;
    logic irq_any;
    logic [SRC_W-1:0] xfer_pick;
    logic [SRC_W-1:0] irq_pick;
    logic [4:0] lat_sum;
    logic [3:0] lat;
    logic inject;

    assign xfer_pend = flag_r & irq_en_r & xfer_sel_r;
    assign irq_pend = flag_r & irq_en_r & ~xfer_sel_r;
    assign inject = (state_r == XS_WAIT) && (cnt_r <= 4'h1) && !ext_bus_busy;

    always_comb begin
        xfer_pick = '0;
        irq_pick = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (xfer_pend[i]) begin
                xfer_pick = SRC_W'(i);
            end
            if (irq_pend[i]) begin
                irq_pick = SRC_W'(i);
            end
        end
        xfer_any = |xfer_pend;
        irq_any = |irq_pend;
        lat_sum = {1'b0, flag_in_first_clk ? LAT_FIRST_CLK : LAT_LAST_CLK}
                + {1'b0, hold_n2_n1 ? LAT_HOLD : 4'h0}
                + {1'b0, hold_n1_n ? LAT_HOLD : 4'h0}
                + {1'b0, n_slow_op ? LAT_SLOW_OP : 4'h0}
                + {1'b0, n_psw_after_flags ? LAT_PSW : 4'h0};
        lat = (lat_sum > {1'b0, LAT_MAX}) ? LAT_MAX : lat_sum[3:0];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= XS_IDLE;
            cnt_r <= '0;
            resume_r <= '0;
            src_r <= '0;
        end else begin
            unique case (state_r)
                XS_IDLE: begin
                    if (xfer_any) begin
                        src_r <= xfer_pick;
                        cnt_r <= lat - 4'h1;
                        state_r <= XS_ARB;
                    end
                end
                XS_ARB: begin
                    if (n_reads_channel_ctrl) begin
                        cnt_r <= cnt_r;
                    end else begin
                        cnt_r <= cnt_r - 4'h1;
                        state_r <= XS_WAIT;
                    end
                end
                XS_WAIT: begin
                    if (inject) begin
                        resume_r <= RESUME_CLKS;
                        state_r <= XS_RESUME;
                    end else if (!ext_bus_busy) begin
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
                XS_RESUME: begin
                    if (resume_r > 2'h1) begin
                        resume_r <= resume_r - 2'h1;
                    end else if (!xfer_operand_busy) begin
                        resume_r <= '0;
                        state_r <= XS_IDLE;
                    end
                end
            endcase
        end
    end

    // Request flags, set wins over clear
    logic [NUM_SRC-1:0] clr;
    always_comb begin
        clr = '0;
        if (wr_now && avs_address == OFS_FLAGS) begin
            clr = avs_writedata[NUM_SRC-1:0];
        end
        if (inject) begin
            clr[src_r] = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            flag_r <= '0;
        end else begin
            flag_r <= (flag_r & ~clr) | evt;
        end
    end

    // Outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            transfer_start <= 1'b0;
            transfer_source <= '0;
            instr_stall <= 1'b0;
            irq_req <= 1'b0;
            irq_source <= '0;
        end else begin
            transfer_start <= inject;
            if (inject) begin
                transfer_source <= src_r;
            end
            instr_stall <= inject || (state_r == XS_RESUME &&
                           (resume_r > 2'h1 || xfer_operand_busy));
            irq_req <= irq_any;
            irq_source <= irq_pick;
        end
    end

    // Power-down wake from fast inputs
    logic wake_any;
    always_comb begin
        wake_any = 1'b0;
        for (int i = 0; i < NUM_FAST; i++) begin
            unique case (fast_edge_r[2*i +: 2])
                2'b00: ;
                2'b01: wake_any = wake_any | fast_cur[i];
                2'b10: wake_any = wake_any | ~fast_cur[i];
                2'b11: wake_any = wake_any | (fast_cur[i] ^ fast_prev_r[i]);
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wake_request <= 1'b0;
        end else begin
            wake_request <= sys_cfg_r & powerdown_active & wake_any;
        end
    end

    // Read data
    always_ff @(posedge clk) begin
        if (rst) begin
            avs_readdata <= '0;
        end else if (rd_seen) begin
            avs_readdata <= '0;
            if (avs_address >= OFS_CC_CAP_BASE &&
                avs_address < OFS_CC_CAP_BASE + 8'(4 * NUM_CC)) begin
                avs_readdata[TIMER_W-1:0] <= cc_cap_r[avs_address[5:2]];
            end else begin
                unique case (avs_address)
                    OFS_CC_MODE_LO: begin
                        for (int i = 0; i < 8; i++) begin
                            avs_readdata[3*i +: 3] <= cc_mode_r[i];
                        end
                    end
                    OFS_CC_MODE_HI: begin
                        for (int i = 0; i < 8; i++) begin
                            avs_readdata[3*i +: 3] <= cc_mode_r[8+i];
                        end
                    end
                    OFS_IRQ_EN: avs_readdata[NUM_SRC-1:0] <= irq_en_r;
                    OFS_XFER_SEL: avs_readdata[NUM_SRC-1:0] <= xfer_sel_r;
                    OFS_FLAGS: avs_readdata[NUM_SRC-1:0] <= flag_r;
                    OFS_AUX_A_CTRL: avs_readdata[5:0] <= aux_a_ctrl_r;
                    OFS_AUX_B_CTRL: avs_readdata[5:0] <= aux_b_ctrl_r;
                    OFS_CAP_CTRL: avs_readdata[2:0] <= cap_ctrl_r;
                    OFS_FAST_EDGE: avs_readdata[15:0] <= fast_edge_r;
                    OFS_FAST_SRC: avs_readdata[15:0] <= fast_src_r;
                    OFS_SYS_CFG: avs_readdata[PWD_CFG_BIT] <= sys_cfg_r;
                    OFS_AUX_A_VAL: avs_readdata[TIMER_W-1:0] <= aux_a_val_r;
                    OFS_AUX_B_VAL: avs_readdata[TIMER_W-1:0] <= aux_b_val_r;
                    OFS_CAPTURE_RELOAD_REGISTER: avs_readdata[TIMER_W-1:0] <= capture_reload_register_r;
                    OFS_STATUS: avs_readdata[11:0] <= {src_r, cnt_r, 1'b0, state_r};
                    default: ;
                endcase
            end
        end
    end
endmodule : ext_irq_and_pec_timing

// File: verification/pin_source.sv
// Event source model driving the request pins
`timescale 1ns/1ps
module pin_source (
    // Clock and command
    input wire logic clk,
    input wire logic [26:0] lvl,
    // Pins
    output logic [15:0] cc,
    output logic [2:0] gpt,
    output logic [7:0] alt
);
    // Levels change just after an edge, unrelated to sampling
    always_ff @(posedge clk) begin
        {alt, gpt, cc} <= lvl;
    end
endmodule : pin_source

// File: verification/ext_irq_and_pec_timing_properties.sv
// Port checker for the request and transfer timing block
`timescale 1ns/1ps
module ext_irq_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bus
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Transfer
    input wire logic ext_bus_busy,
    input wire logic transfer_start,
    input wire logic [ext_irq_pkg::SRC_W-1:0] transfer_source,
    input wire logic instr_stall,
    input wire logic wake_request
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_ans; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
    a_ans: assert property (p_ans) else $error("bus answer late");
    property p_pulse; !avs_waitrequest |=> avs_waitrequest; endproperty
    a_pulse: assert property (p_pulse) else $error("waitrequest low too long");
    property p_cause; !avs_waitrequest |-> $past(avs_read || avs_write); endproperty
    a_cause: assert property (p_cause) else $error("answer without request");
    property p_rhold; $changed(avs_readdata) |-> !avs_waitrequest; endproperty
    a_rhold: assert property (p_rhold) else $error("read data moved");
    property p_gap; transfer_start |=> !transfer_start [*3]; endproperty
    a_gap: assert property (p_gap) else $error("transfers too close");
    property p_stall; transfer_start |-> instr_stall ##1 instr_stall; endproperty
    a_stall: assert property (p_stall) else $error("stall too short");
    property p_srise; $rose(instr_stall) |-> transfer_start; endproperty
    a_srise: assert property (p_srise) else $error("stall without transfer");
    property p_src; $changed(transfer_source) |-> transfer_start; endproperty
    a_src: assert property (p_src) else $error("source moved alone");
    property p_busy; transfer_start |-> !$past(ext_bus_busy); endproperty
    a_busy: assert property (p_busy) else $error("injected while bus busy");
    c_start: cover property (transfer_start);
    c_stall: cover property (instr_stall ##1 !instr_stall);
    c_wake: cover property (wake_request);
endmodule : ext_irq_chk
bind ext_irq_and_pec_timing ext_irq_chk ext_irq_chk_inst (.clk(clk), .rst(rst),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ext_bus_busy(ext_bus_busy),
    .transfer_start(transfer_start), .transfer_source(transfer_source),
    .instr_stall(instr_stall), .wake_request(wake_request));

// File: verification/ext_irq_and_pec_timing_tb_top.sv
// Self-checking bench for the external request block
`timescale 1ns/1ps
module ext_irq_and_pec_timing_tb_top;
    import ext_irq_pkg::*;
    logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, busy = 1'b0, pd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wd = 32'h0, rdata;
    logic [5:0] cond = 6'h00;
    logic [26:0] lvl = 27'h0;
    logic [15:0] cc;
    logic [2:0] gpt;
    logic [7:0] alt;
    logic wreq, start, stall, irq, wake;
    logic [SRC_W-1:0] tsrc, isrc;
    int n_mismatch = 0, n_compared = 0;
    always #5 clk = !clk;
    pin_source pin_source_inst (.clk(clk), .lvl(lvl), .cc(cc), .gpt(gpt), .alt(alt));
    ext_irq_and_pec_timing ext_irq_and_pec_timing_inst (.clk(clk), .rst(rst),
        .avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
        .avs_byteenable(4'hf), .avs_readdata(rdata), .avs_waitrequest(wreq),
        .cc_pin_in(cc), .aux_timer_a_input(gpt[0]), .aux_timer_b_input(gpt[1]),
        .gpt_capture_pin(gpt[2]), .fast_alt_source(alt), .capcom_timer(16'h0a5c),
        .core_timer_three(16'h3c5a), .flag_in_first_clk(cond[0]), .hold_n2_n1(cond[1]),
        .hold_n1_n(cond[2]), .n_slow_op(cond[3]), .n_psw_after_flags(cond[4]),
        .n_reads_channel_ctrl(cond[5]), .ext_bus_busy(busy), .xfer_operand_busy(1'b0),
        .powerdown_active(pd), .transfer_start(start), .transfer_source(tsrc),
        .instr_stall(stall), .irq_req(irq), .irq_source(isrc), .wake_request(wake));
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int i;
        @(posedge clk);
        addr <= a;
        wd <= d;
        rd <= !w;
        wr <= w;
        for (i = 0; i < 20 && wreq !== 1'b0; i++) @(posedge clk);
        if (i == 20) begin
            n_mismatch++;
            close_out();
        end
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    // Rise then fall on pin p; e is {fall, rise}
    task automatic edge_test(input int p, input logic [7:0] a, input logic [31:0] c,
                             input int b, input logic [1:0] e);
        logic [31:0] q;
        bus(1'b1, a, c, q);
        for (int k = 0; k < 2; k++) begin
            bus(1'b1, OFS_FLAGS, 32'hffff_ffff, q);
            lvl[p] <= (k == 0);
            repeat (30) @(posedge clk);
            bus(1'b0, OFS_FLAGS, 32'h0, q);
            chk({31'h0, q[b]}, {31'h0, e[k]});
        end
    endtask : edge_test
    task automatic t_edges();
        logic [31:0] q;
        bus(1'b1, OFS_CAPTURE_RELOAD_REGISTER, 32'h1111, q);
        for (int m = 1; m < 4; m++) begin
            edge_test(0, OFS_CC_MODE_LO, m, 0, m[1:0]);
            edge_test(16, OFS_AUX_A_CTRL, (m << 3) | 5, 16, m[1:0]);
            edge_test(18, OFS_CAP_CTRL, m, 18, m[1:0]);
            edge_test(8, OFS_FAST_EDGE, m, 8, m[1:0]);
        end
        edge_test(17, OFS_AUX_B_CTRL, 32'h18, 17, 2'b00);
        bus(1'b1, OFS_FAST_SRC, 32'h1, q);
        edge_test(19, OFS_FAST_EDGE, 32'h3, 8, 2'b11);
        bus(1'b1, OFS_FAST_SRC, 32'h0, q);
        bus(1'b0, OFS_CC_CAP_BASE, 32'h0, q);
        chk(q, 32'h0000_0a5c);
        bus(1'b0, OFS_AUX_A_VAL, 32'h0, q);
        chk(q, 32'h0000_3c5a);
        bus(1'b0, OFS_CAPTURE_RELOAD_REGISTER, 32'h0, q);
        chk(q, 32'h0000_1111);
        $display("edge test done");
    endtask : t_edges
    // Toggle fast pin, count cycles to transfer start
    task automatic lat_run(input logic [6:0] c, output int n);
        repeat (6) @(posedge clk);
        cond <= {1'b0, c[4:0]};
        lvl[8] <= !lvl[8];
        for (n = 0; n < 40 && start !== 1'b1; n++) begin
            @(posedge clk);
            busy <= c[6] && (n == 5 || n == 6) && start !== 1'b1;
            cond[5] <= c[5] && n == 4;
        end
        if (n == 40) chk(n, 0);
    endtask : lat_run
    task automatic t_latency();
        logic [31:0] q;
        int n0, n, k;
        logic [6:0] rows [8] = '{7'h01, 7'h02, 7'h06, 7'h08, 7'h10, 7'h1f, 7'h20, 7'h40};
        int dly [8] = '{1, 1, 2, 2, 2, 6, 1, 2};
        bus(1'b1, OFS_FAST_EDGE, 32'h3, q);
        bus(1'b1, OFS_XFER_SEL, 32'h100, q);
        bus(1'b1, OFS_FLAGS, 32'hffff_ffff, q);
        bus(1'b1, OFS_IRQ_EN, 32'h100, q);
        lat_run(7'h00, n0);
        chk({27'h0, tsrc}, 32'h8);
        for (k = 0; k < 9 && stall === 1'b1; k++) @(posedge clk);
        chk(k, 2);
        bus(1'b0, OFS_FLAGS, 32'h0, q);
        chk({31'h0, q[8]}, 32'h0);
        for (int i = 0; i < 8; i++) begin
            lat_run(rows[i], n);
            chk(n - n0, dly[i]);
        end
        $display("latency test done");
    endtask : t_latency
    task automatic t_wake();
        logic [31:0] q;
        bus(1'b1, OFS_XFER_SEL, 32'h0, q);
        lvl[8] <= 1'b0;
        bus(1'b1, OFS_FAST_EDGE, 32'h1, q);
        bus(1'b1, OFS_SYS_CFG, 32'h1, q);
        lvl[8] <= 1'b1;
        pd <= 1'b1;
        repeat (10) @(posedge clk);
        chk({31'h0, wake}, 32'h1);
        chk({26'h0, irq, isrc}, 32'h28);
        bus(1'b1, OFS_SYS_CFG, 32'h0, q);
        repeat (4) @(posedge clk);
        chk({31'h0, wake}, 32'h0);
        $display("wake test done");
    endtask : t_wake
    initial begin
        logic [31:0] q;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        bus(1'b1, OFS_IRQ_EN, 32'hffff_ffff, q);
        bus(1'b0, OFS_IRQ_EN, 32'h0, q);
        chk(q, 32'h0007_ffff);
        bus(1'b1, 8'h3c, 32'h1234_5678, q);
        bus(1'b0, 8'h3c, 32'h0, q);
        chk(q, 32'h0);
        bus(1'b1, OFS_IRQ_EN, 32'h0, q);
        $display("register test done");
        t_edges();
        t_latency();
        t_wake();
        close_out();
    end
endmodule : ext_irq_and_pec_timing_tb_top
